//--- design/dalag_aggregator.sv
/*
 diagnostic alarm aggregator: latches fault flags, classes them static or
 temporary, gates them onto the interrupt pin and forces analog outputs.
 assumes the nine monitor fault inputs come from asynchronous analog monitors (synchronised
 here) and control bits from same-clock register logic.
*/
// Function
// - every detected fault sets its own flag bit in the status vector
// - per-source enables; only enabled flags may raise the interrupt pin
// - interrupt can also force the four analog outputs to diagnostic state
// - static flags hold while error persists, cleared only by power-on reset or, for the buffer flag, a host clear
// - temporary flags clear automatically once the cause disappears, except the nonvolatile single-bit flag, held until the next check
// - continuous checks always evaluated; start-up checks only during start-up
// - temporary flag when external supply above maximum, hysteresis upstream
// - temporary flag when external supply below minimum, hysteresis upstream
// - temporary flag on internal analog supply under-voltage
// - temporary continuous flag when a serial data transfer fails
// - static flag on shadow register double-bit error
// - temporary flag on shadow single-bit error, corrected value delivered
// - start-up: static flag on nonvolatile word double-bit error
// - start-up: temporary flag on nonvolatile single-bit error, output corrected
// - temporary flag when transmitter oscillator frequency leaves programmed range
// - temporary flag when transmitter oscillator stops
// - static flag on internal clock oscillator failure
// - nonzero watchdog value counts down, flags and reloads at each expiry
// - writing zero to watchdog value stops the counting
// - output mean offset fault: temporary flag, always disables analog outputs
// - overload persisting eight checks: permanent shutdown, static flag set
// - permanent shutdown released by reset or clearing the static flag
// - static flag on mechanical damage
// - after over-current debounce time all four analog outputs go tri-state
`timescale 1ns/100ps
module dalag_aggregator #(
    parameter int WDOG_W = dalag_pkg::WDOG_WIDTH,
    parameter int FREQ_W = 12,
    parameter int DATA_W = 16
) (
    // clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_nrst,
    // asynchronous monitor inputs
    input  wire logic                   i_vdd_over,
    input  wire logic                   i_vdd_under,
    input  wire logic                   i_ana_under,
    input  wire logic                   i_data_access_fail,
    input  wire logic                   i_int_osc_fail,
    input  wire logic                   i_bus_fail,
    input  wire logic                   i_mech_damage,
    input  wire logic                   i_dc_offset,
    input  wire logic                   i_over_current,
    // same-clock event and data inputs
    input  wire logic                   i_protocol_fail,
    input  wire logic                   i_startup,
    input  wire logic                   i_lc_running,
    input  wire logic                   i_freq_valid,
    input  wire logic [FREQ_W-1:0]      i_freq_measure,
    input  wire logic [FREQ_W-1:0]      i_freq_low,
    input  wire logic [FREQ_W-1:0]      i_freq_high,
    // shadow register and nonvolatile word check results
    input  wire logic                   i_shadow_check,
    input  wire logic                   i_shadow_double_bit_detect,
    input  wire logic                   i_shadow_single_bit_detect,
    input  wire logic [DATA_W-1:0]      i_shadow_data,
    input  wire logic [DATA_W-1:0]      i_shadow_syndrome_fix,
    input  wire logic                   i_nonvolatile_store_check,
    input  wire logic                   i_nonvolatile_store_double_bit_detect,
    input  wire logic                   i_nonvolatile_store_single_bit_detect,
    input  wire logic [DATA_W-1:0]      i_nonvolatile_store_data,
    input  wire logic [DATA_W-1:0]      i_nonvolatile_store_fix,
    // control from host registers
    input  wire logic [16:0]            i_enable,
    input  wire logic                   i_diag_outputs_en,
    input  wire logic                   i_wdog_load,
    input  wire logic [WDOG_W-1:0]      i_wdog_value,
    input  wire logic                   i_buf_static_clear,
    // status and corrected data
    output logic [16:0]                 o_flags,
    output logic [DATA_W-1:0]           o_shadow_single_bit_correct,
    output logic [DATA_W-1:0]           o_nonvolatile_store_single_bit_correct,
    // pins
    output logic                        o_addr_select_interrupt_pin_out,
    output logic                        o_addr_select_interrupt_pin_oe,
    output logic                        o_analog_force_diag,
    output logic                        o_analog_out_oe
);

    // two-flop synchronisers for the asynchronous monitors
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    assign async_in = {i_over_current, i_dc_offset, i_mech_damage, i_bus_fail,
                       i_int_osc_fail, i_data_access_fail, i_ana_under,
                       i_vdd_under, i_vdd_over};

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end

    logic s_over_current;
    assign s_over_current = sync_b[8];

    // frequency window check, only on a fresh measurement
    function automatic logic out_of_range(input logic [FREQ_W-1:0] v,
                                          input logic [FREQ_W-1:0] lo,
                                          input logic [FREQ_W-1:0] hi);
        out_of_range = (v < lo) || (v > hi);
    endfunction

    logic freq_bad;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            freq_bad <= 1'b0;
        end else if (i_freq_valid) begin
            freq_bad <= out_of_range(i_freq_measure, i_freq_low, i_freq_high);
        end
    end

    // per-cycle detections; temporary sources are present levels
    logic [16:0] detect;
    logic        wdog_expire;
    logic        buf_trip;
    always_comb begin
        detect = '0;
        detect[dalag_pkg::F_VDD_OVER]    = sync_b[0];
        detect[dalag_pkg::F_VDD_UNDER]   = sync_b[1];
        detect[dalag_pkg::F_ANA_UNDER]   = sync_b[2];
        detect[dalag_pkg::F_DATA_ACCESS] = sync_b[3];
        detect[dalag_pkg::F_PROTOCOL]    = i_protocol_fail;
        detect[dalag_pkg::F_SHADOW_DBL]  = i_shadow_check & i_shadow_double_bit_detect;
        detect[dalag_pkg::F_SHADOW_SGL]  = i_shadow_check & i_shadow_single_bit_detect;
        detect[dalag_pkg::F_NV_DBL]      = i_nonvolatile_store_check
                                         & i_nonvolatile_store_double_bit_detect;
        detect[dalag_pkg::F_NV_SGL]      = i_nonvolatile_store_check
                                         & i_nonvolatile_store_single_bit_detect;
        detect[dalag_pkg::F_LC_FREQ]     = freq_bad;
        detect[dalag_pkg::F_LC_STOP]     = ~i_lc_running;
        detect[dalag_pkg::F_INT_OSC]     = sync_b[4];
        detect[dalag_pkg::F_BUS]         = sync_b[5];
        detect[dalag_pkg::F_WATCHDOG]    = wdog_expire;
        detect[dalag_pkg::F_MECH]        = sync_b[6];
        detect[dalag_pkg::F_DC_OFFSET]   = sync_b[7];
        detect[dalag_pkg::F_BUF_STATIC]  = buf_trip;
    end

    // start-up sources are ignored outside the start-up sequence
    logic [16:0] evaluated;
    assign evaluated = detect & (i_startup ? 17'h1_ffff : ~dalag_pkg::STARTUP_MASK);

    // flag store: static bits sticky, temporary bits follow the cause, start-up single-bit flag held between checks
    logic [16:0] flags;
    genvar g;
    generate
        for (g = 0; g < 17; g++) begin : g_flag
            always_ff @(posedge i_clock or negedge i_nrst) begin
                if (!i_nrst) begin
                    flags[g] <= dalag_pkg::FLAGS_RESET[g];
                end else if (dalag_pkg::STATIC_MASK[g]) begin
                    // new event wins over a host clear in the same cycle
                    if (evaluated[g]) begin
                        flags[g] <= 1'b1;
                    end else if (g == dalag_pkg::F_BUF_STATIC && i_buf_static_clear) begin
                        flags[g] <= 1'b0;
                    end
                end else if (dalag_pkg::STARTUP_MASK[g]) begin
                    // start-up results hold until the next check reports
                    if (i_nonvolatile_store_check) begin
                        flags[g] <= evaluated[g];
                    end
                end else begin
                    flags[g] <= evaluated[g];
                end
            end
        end
    endgenerate
    assign o_flags = flags;

    // corrected data outputs
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_shadow_single_bit_correct            <= '0;
            o_nonvolatile_store_single_bit_correct <= '0;
        end else begin
            o_shadow_single_bit_correct <= i_shadow_single_bit_detect
                ? (i_shadow_data ^ i_shadow_syndrome_fix) : i_shadow_data;
            o_nonvolatile_store_single_bit_correct <= i_nonvolatile_store_single_bit_detect
                ? (i_nonvolatile_store_data ^ i_nonvolatile_store_fix)
                : i_nonvolatile_store_data;
        end
    end

    // watchdog: reload value held, zero stops counting
    logic [WDOG_W-1:0] wdog_reload;
    logic [WDOG_W-1:0] wdog_count;
    assign wdog_expire = (wdog_reload != '0) && (wdog_count == WDOG_W'(1));
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wdog_reload <= '0;
            wdog_count  <= '0;
        end else if (i_wdog_load) begin
            wdog_reload <= i_wdog_value;
            wdog_count  <= i_wdog_value;
        end else if (wdog_reload == '0) begin
            wdog_count <= '0;
        end else if (wdog_expire) begin
            wdog_count <= wdog_reload;
        end else begin
            wdog_count <= wdog_count - WDOG_W'(1);
        end
    end

    // over-current sequencer: debounce, tri-state, retry, count checks
    typedef enum logic [1:0] {OC_IDLE, OC_DEBOUNCE, OC_OFF, OC_LOCKED} dalag_oc_type;
    dalag_oc_type oc_state;
    logic [15:0]  oc_timer;
    logic [3:0]   oc_checks;
    assign buf_trip = (oc_state == OC_OFF) && (oc_timer == 16'h0000)
                   && (oc_checks == 4'(dalag_pkg::BUF_CHECKS - 1));

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            oc_state  <= OC_IDLE;
            oc_timer  <= '0;
            oc_checks <= '0;
        end else begin
            unique case (oc_state)
                OC_IDLE: begin
                    oc_checks <= '0;
                    if (s_over_current) begin
                        oc_state <= OC_DEBOUNCE;
                        oc_timer <= 16'(dalag_pkg::OC_DEBOUNCE_CYC - 1);
                    end
                end
                OC_DEBOUNCE: begin
                    if (!s_over_current) begin
                        oc_state <= OC_IDLE;
                    end else if (oc_timer == 16'h0000) begin
                        oc_state <= OC_OFF;
                        oc_timer <= 16'(dalag_pkg::OC_RETRY_CYC - 1);
                    end else begin
                        oc_timer <= oc_timer - 16'h0001;
                    end
                end
                OC_OFF: begin
                    if (oc_timer != 16'h0000) begin
                        oc_timer <= oc_timer - 16'h0001;
                    end else if (buf_trip) begin
                        oc_state <= OC_LOCKED;
                    end else begin
                        oc_checks <= oc_checks + 4'h1;
                        oc_state  <= OC_DEBOUNCE;
                        oc_timer  <= 16'(dalag_pkg::OC_DEBOUNCE_CYC - 1);
                    end
                end
                OC_LOCKED: begin
                    if (!flags[dalag_pkg::F_BUF_STATIC]) begin
                        oc_state <= OC_IDLE;
                    end
                end
            endcase
        end
    end

    // interrupt and output drive
    logic irq;
    assign irq = |(flags & i_enable);
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_addr_select_interrupt_pin_oe <= 1'b0;
            o_analog_force_diag            <= 1'b0;
            o_analog_out_oe                <= 1'b1;
        end else begin
            o_addr_select_interrupt_pin_oe <= irq;
            o_analog_force_diag <= irq & i_diag_outputs_en;
            // offset fault always disables, whatever the diag mode
            o_analog_out_oe <= !(flags[dalag_pkg::F_DC_OFFSET]
                               || oc_state == OC_OFF || oc_state == OC_LOCKED);
        end
    end
    // open-drain active-low pin: only ever drives low
    assign o_addr_select_interrupt_pin_out = 1'b0;

    // assertions
    a_irq_follows_enable: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_addr_select_interrupt_pin_oe == $past(irq))
        else $error("interrupt pin does not follow enabled flags");
    a_static_sticky: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $past(flags[dalag_pkg::F_MECH]) |-> flags[dalag_pkg::F_MECH])
        else $error("static flag dropped");
    a_temp_clears: assert property (@(posedge i_clock) disable iff (!i_nrst)
        !sync_b[0] |=> !flags[dalag_pkg::F_VDD_OVER])
        else $error("temporary flag held after cause gone");
    a_startup_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (!i_startup && !flags[dalag_pkg::F_NV_DBL]) |=> !flags[dalag_pkg::F_NV_DBL])
        else $error("start-up flag set outside start-up");
    sequence s_wdog_run;
        (wdog_reload != '0) && !i_wdog_load && wdog_expire;
    endsequence
    a_wdog_reload: assert property (@(posedge i_clock) disable iff (!i_nrst)
        s_wdog_run |=> (wdog_count == wdog_reload) && flags[dalag_pkg::F_WATCHDOG])
        else $error("watchdog did not flag and reload");
    a_wdog_stop: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_wdog_load && i_wdog_value == '0) ##1 !i_wdog_load |-> (wdog_count == '0) [*2])
        else $error("watchdog still counting after zero");
    a_offset_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
        flags[dalag_pkg::F_DC_OFFSET] |=> !o_analog_out_oe)
        else $error("outputs on during offset fault");
    a_lock_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
        buf_trip |=> ##1 (!o_analog_out_oe && flags[dalag_pkg::F_BUF_STATIC]))
        else $error("buffer lock did not shut outputs");
    a_debounce_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (oc_state == OC_DEBOUNCE && s_over_current && oc_timer == 16'h0000)
        |=> ##1 !o_analog_out_oe)
        else $error("outputs not tri-stated after debounce");
    a_force_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (irq && i_diag_outputs_en) |=> o_analog_force_diag)
        else $error("diagnostic forcing missing");
    a_force_mode: assert property (@(posedge i_clock) disable iff (!i_nrst)
        !i_diag_outputs_en |=> !o_analog_force_diag)
        else $error("diagnostic forcing while disabled");
    a_protocol_flag: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_protocol_fail |=> flags[dalag_pkg::F_PROTOCOL])
        else $error("protocol failure not flagged");
    a_lc_stop: assert property (@(posedge i_clock) disable iff (!i_nrst)
        !i_lc_running |=> flags[dalag_pkg::F_LC_STOP])
        else $error("stopped oscillator not flagged");
    a_shadow_fix: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_shadow_single_bit_detect |=> o_shadow_single_bit_correct
            == ($past(i_shadow_data) ^ $past(i_shadow_syndrome_fix)))
        else $error("shadow data not corrected");
    a_buf_release: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_buf_static_clear && !buf_trip) |=> !flags[dalag_pkg::F_BUF_STATIC])
        else $error("buffer flag not cleared by host");
endmodule

//--- design/dalag_pkg.sv
/*
 diagnostic alarm aggregator package: flag indices, widths, timing counts.
 assumes a single 200 MHz clock domain.
*/
package dalag_pkg;
    // flag positions in the status vector
    localparam int FLAG_COUNT       = 17;
    localparam int F_VDD_OVER       = 0;
    localparam int F_VDD_UNDER      = 1;
    localparam int F_ANA_UNDER      = 2;
    localparam int F_DATA_ACCESS    = 3;
    localparam int F_PROTOCOL       = 4;
    localparam int F_SHADOW_DBL     = 5;
    localparam int F_SHADOW_SGL     = 6;
    localparam int F_NV_DBL         = 7;
    localparam int F_NV_SGL         = 8;
    localparam int F_LC_FREQ        = 9;
    localparam int F_LC_STOP        = 10;
    localparam int F_INT_OSC        = 11;
    localparam int F_BUS            = 12;
    localparam int F_WATCHDOG       = 13;
    localparam int F_MECH           = 14;
    localparam int F_DC_OFFSET      = 15;
    localparam int F_BUF_STATIC     = 16;
    // static-class mask (1 = static), start-up-class mask (1 = start-up only)
    localparam logic [16:0] STATIC_MASK  = 17'h1_68a0;
    localparam logic [16:0] STARTUP_MASK = 17'h0_0180;
    localparam logic [16:0] FLAGS_RESET  = 17'h0_0000;
    // buffer failure: number of temporary checks before permanent shutdown
    localparam int          BUF_CHECKS   = 8;
    // over-current debounce time and derived cycle count
    localparam int          CLOCK_MHZ    = 200;
    localparam int          OC_DEBOUNCE_NS = 100;
    localparam int          OC_DEBOUNCE_CYC = (OC_DEBOUNCE_NS * CLOCK_MHZ) / 1000;
    localparam int          OC_RETRY_NS  = 1000;
    localparam int          OC_RETRY_CYC = (OC_RETRY_NS * CLOCK_MHZ) / 1000;
    localparam int          WDOG_WIDTH   = 16;
endpackage

//--- sim/dalag_host_model.sv
/*
 host controller model: watches the open-drain interrupt pin, loads the
 watchdog and clears the buffer lock on bench command.
 assumes a pull-up on the pin and bench commands set at the falling edge.
*/
`timescale 1ns/100ps
module dalag_host_model (
    // clock and pin
    input  wire logic        i_clock,
    input  wire logic        i_pin_oe,
    // commands from the bench
    input  wire logic        i_cmd_wdog,
    input  wire logic [15:0] i_cmd_value,
    input  wire logic        i_cmd_clear,
    // towards the device
    output logic             o_wdog_load,
    output logic [15:0]      o_wdog_value,
    output logic             o_buf_clear,
    output logic             o_pin_level
);
    // released pin floats to the pull-up level
    assign o_pin_level = i_pin_oe ? 1'b0 : 1'b1;

    // idle values before the first command
    initial begin
        o_wdog_load  = 1'b0;
        o_wdog_value = 16'h0000;
        o_buf_clear  = 1'b0;
    end

    // one cycle wide requests, launched off the sampling edge
    always @(negedge i_clock) begin
        o_wdog_load  <= i_cmd_wdog;
        o_wdog_value <= i_cmd_value;
        o_buf_clear  <= i_cmd_clear;
    end
endmodule

//--- sim/diagnostic_alarm_aggregator_tb_top.sv
/*
 self-checking bench for the alarm aggregator, random and corner cases.
 assumes the host model in dalag_host_model.sv and default parameters.
*/
`timescale 1ns/100ps
module diagnostic_alarm_aggregator_tb_top;
    logic        clock, nrst, prot, startup, lc, fvalid, den;
    logic        sh_chk, sh_dbl, sh_sgl, nv_chk, nv_dbl, nv_sgl;
    logic        cmd_wdog, cmd_clear, wdog_load, buf_clear, pin_oe, pin_out;
    logic        force_diag, out_oe, pin_level;
    logic [8:0]  mon;
    logic [11:0] fmeas, flo, fhi;
    logic [15:0] sh_data, sh_fix, nv_data, nv_fix, cmd_value, wdog_value;
    logic [15:0] sh_cor, nv_cor;
    logic [16:0] en, ef, flags;
    logic [31:0] r;
    int          miscompares, checks_done, cycles;

    dalag_aggregator dalag_aggregator_inst (
        .i_clock(clock), .i_nrst(nrst), .i_vdd_over(mon[0]), .i_vdd_under(mon[1]),
        .i_ana_under(mon[2]), .i_data_access_fail(mon[3]), .i_int_osc_fail(mon[4]),
        .i_bus_fail(mon[5]), .i_mech_damage(mon[6]), .i_dc_offset(mon[7]),
        .i_over_current(mon[8]), .i_protocol_fail(prot), .i_startup(startup),
        .i_lc_running(lc), .i_freq_valid(fvalid), .i_freq_measure(fmeas),
        .i_freq_low(flo), .i_freq_high(fhi), .i_shadow_check(sh_chk),
        .i_shadow_double_bit_detect(sh_dbl), .i_shadow_single_bit_detect(sh_sgl),
        .i_shadow_data(sh_data), .i_shadow_syndrome_fix(sh_fix),
        .i_nonvolatile_store_check(nv_chk),
        .i_nonvolatile_store_double_bit_detect(nv_dbl),
        .i_nonvolatile_store_single_bit_detect(nv_sgl),
        .i_nonvolatile_store_data(nv_data), .i_nonvolatile_store_fix(nv_fix),
        .i_enable(en), .i_diag_outputs_en(den), .i_wdog_load(wdog_load),
        .i_wdog_value(wdog_value), .i_buf_static_clear(buf_clear), .o_flags(flags),
        .o_shadow_single_bit_correct(sh_cor),
        .o_nonvolatile_store_single_bit_correct(nv_cor),
        .o_addr_select_interrupt_pin_out(pin_out),
        .o_addr_select_interrupt_pin_oe(pin_oe),
        .o_analog_force_diag(force_diag), .o_analog_out_oe(out_oe));

    dalag_host_model dalag_host_model_inst (
        .i_clock(clock), .i_pin_oe(pin_oe), .i_cmd_wdog(cmd_wdog),
        .i_cmd_value(cmd_value), .i_cmd_clear(cmd_clear), .o_wdog_load(wdog_load),
        .o_wdog_value(wdog_value), .o_buf_clear(buf_clear), .o_pin_level(pin_level));

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        tick(20);
        nrst = 1'b1;
        tick(1);
    endtask

    // nonblocking so the host model sees the command one edge later
    task automatic wdog(input logic [15:0] v);
        cmd_value <= v;
        cmd_wdog  <= 1'b1;
        tick(1);
        cmd_wdog  <= 1'b0;
        tick(1);
    endtask

    task automatic print_verdict();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        {nrst, prot, startup, fvalid, den, sh_chk, sh_dbl, sh_sgl} = '0;
        {nv_chk, nv_dbl, nv_sgl, cmd_wdog, cmd_clear, mon, en} = '0;
        {fmeas, flo, fhi, sh_data, sh_fix, nv_data, nv_fix, cmd_value} = '0;
        lc = 1'b1;
        r = $urandom(46274);
        do_reset();
        check("flags reset", flags, 17'h0_0000);
        check("out oe reset", out_oe, 1'b1);
        // random temporary faults, enables and forcing, all-on and all-off first
        for (int i = 0; i < 24; i++) begin
            r = (i == 0) ? '1 : (i == 1) ? '0 : $urandom;
            mon[3:0] = r[3:0];
            mon[5] = r[4];
            prot = r[5];
            lc = r[6];
            den = r[7];
            en = (i == 0) ? '1 : r[24:8];
            tick(6);
            ef = '0;
            ef[3:0] = r[3:0];
            ef[12] = r[4];
            ef[4] = r[5];
            ef[10] = !r[6];
            check("flags", flags, ef);
            check("irq oe", pin_oe, |(ef & en));
            check("irq pin", pin_level, !(|(ef & en)));
            check("pin out", pin_out, 1'b0);
            check("force diag", force_diag, den & |(ef & en));
        end
        {mon, prot, den} = '0;
        lc = 1'b1;
        // frequency window, both inclusive edges included
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            flo = {1'b0, r[10:0]};
            fhi = flo + 12'h100;
            fmeas = (i == 0) ? fhi : (i == 1) ? flo : r[23:12];
            fvalid = 1'b1;
            tick(1);
            fvalid = 1'b0;
            tick(3);
            check("freq flag", flags[9], (fmeas < flo) || (fmeas > fhi));
        end
        // shadow single then double bit errors
        r = $urandom;
        sh_data = r[15:0];
        sh_fix = 16'h0001 << r[19:16];
        sh_chk = 1'b1;
        sh_sgl = 1'b1;
        tick(3);
        check("shadow sgl", flags[6], 1'b1);
        check("shadow cor", sh_cor, sh_data ^ sh_fix);
        sh_sgl = 1'b0;
        sh_dbl = 1'b1;
        tick(1);
        sh_dbl = 1'b0;
        tick(3);
        check("shadow flags", flags[6:5], 2'b01);
        // nonvolatile checks ignored outside start-up, taken inside
        nv_data = r[31:16];
        nv_fix = 16'h8000;
        {nv_chk, nv_dbl, nv_sgl} = 3'b111;
        tick(3);
        check("nv outside", flags[8:7], 2'b00);
        startup = 1'b1;
        tick(3);
        check("nv flags", flags[8:7], 2'b11);
        check("nv cor", nv_cor, nv_data ^ nv_fix);
        {nv_chk, nv_dbl, nv_sgl, startup} = '0;
        // static async faults pulsed briefly must stay latched
        mon[4] = 1'b1;
        mon[6] = 1'b1;
        tick(4);
        mon[4] = 1'b0;
        mon[6] = 1'b0;
        tick(5);
        check("osc mech", {flags[14], flags[11]}, 2'b11);
        // offset fault turns outputs off with forcing disabled
        mon[7] = 1'b1;
        tick(6);
        check("dc flag", flags[15], 1'b1);
        check("dc oe", out_oe, 1'b0);
        mon[7] = 1'b0;
        tick(6);
        check("dc clear", {flags[15], out_oe}, 2'b01);
        // watchdog expiry after ten counts
        wdog(16'h000a);
        tick(4);
        check("wdog early", flags[13], 1'b0);
        tick(10);
        check("wdog fired", flags[13], 1'b1);
        // reset in mid-run clears the static flags
        do_reset();
        check("flags rst", flags, 17'h0_0000);
        wdog(16'h0005);
        wdog(16'h0000);
        tick(40);
        check("wdog stop", flags[13], 1'b0);
        // persistent overload: debounce, eight checks, lock, host clear
        mon[8] = 1'b1;
        tick(30);
        check("oc off", {flags[16], out_oe}, 2'b00);
        tick(2200);
        check("oc lock", {flags[16], out_oe}, 2'b10);
        mon[8] = 1'b0;
        tick(300);
        check("oc held", {flags[16], out_oe}, 2'b10);
        cmd_clear <= 1'b1;
        tick(1);
        cmd_clear <= 1'b0;
        tick(5);
        check("oc clear", {flags[16], out_oe}, 2'b01);
        print_verdict();
    end
endmodule
